// ==== core/cpfs_status_bank.v ====
`timescale 1ns/1ps
`default_nettype none
`include "cpfs_defines.vh"
module cpfs_status_bank (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // register access from the control interface decoder
  input  wire       regWrEn,
  input  wire       regRdEn,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  output reg  [7:0] regRdData,
  // live power state from the analog and pdm channels
  input  wire [5:0] adcChanOn,
  input  wire [1:0] pdmChanOn,
  input  wire       deviceActive,
  input  wire       boostOn,
  input  wire       micSupplyOn,
  // live fault shutdown state from the fault detectors
  input  wire [5:0] adcInputFault,
  input  wire       micSupplyFault,
  // converter power control input and control outputs
  input  wire       converterPowerOn,
  output reg  [7:0] chanPowerEnable,
  output reg        recoverPulse,
  output reg  [7:0] pageSel
);

  reg       rstMeta_r;
  reg       rstSync_r;
  reg       recover_r;
  reg       recover_nxt;
  reg [7:0] chanSts_r;
  reg [7:0] modeSts_r;
  reg [7:0] rdData_nxt;
  reg [7:0] chanSts_nxt;
  reg [7:0] modeSts_nxt;
  reg [2:0] modeCode;
  wire      statusPage;

  // reset release through two flops; assertion stays asynchronous
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  assign statusPage = (pageSel == `CPFS_STATUS_PAGE); // R13

  // live status assembly, no latching of past events
  always @* begin
    chanSts_nxt = {adcChanOn, pdmChanOn} & {8{converterPowerOn}}; // R1 R2 R12
    if (!deviceActive)
      modeCode = `CPFS_MODE_SLEEP; // R3
    else if (|chanSts_nxt)
      modeCode = `CPFS_MODE_ACTIVE; // R3
    else
      modeCode = `CPFS_MODE_IDLE; // R3
    modeSts_nxt = {modeCode, 5'h00};
    modeSts_nxt[`CPFS_BOOST_BIT] = boostOn; // R5
    modeSts_nxt[`CPFS_MIC_BIT] = micSupplyOn; // R6
    modeSts_nxt[`CPFS_INFLT_BIT] = |adcInputFault; // R7
    modeSts_nxt[`CPFS_BIASFLT_BIT] = micSupplyFault; // R8
    modeSts_nxt[`CPFS_RECOVER_BIT] = recover_r; // R10
  end

  // recovery command: one-cycle request, then cleared by hardware
  always @* begin
    recover_nxt = 1'b0; // R10
    if (regWrEn && statusPage && regAddr == `CPFS_DEVICE_MODE_CODE_ADDR &&
        regWrData[`CPFS_RECOVER_BIT])
      recover_nxt = 1'b1; // R9
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rdData_nxt = regRdData;
    if (regRdEn) begin
      if (regAddr == `CPFS_PAGE_ADDR)
        rdData_nxt = pageSel;
      else if (statusPage && regAddr == `CPFS_CHAN_STS_ADDR)
        rdData_nxt = chanSts_r;
      else if (statusPage && regAddr == `CPFS_DEVICE_MODE_CODE_ADDR)
        rdData_nxt = modeSts_r;
      else
        rdData_nxt = 8'h00;
    end
  end

  // status registers follow live inputs each cycle; ro writes dropped
  always @(posedge clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      chanSts_r       <= `CPFS_CHAN_STS_RST; // R4
      modeSts_r       <= `CPFS_DEVICE_MODE_CODE_RST; // R4
      recover_r       <= 1'b0;
      recoverPulse    <= 1'b0;
      pageSel         <= `CPFS_PAGE_RST;
      regRdData       <= 8'h00;
      chanPowerEnable <= 8'h00;
    end else begin
      chanSts_r       <= chanSts_nxt; // R14
      modeSts_r       <= modeSts_nxt; // R14
      recover_r       <= recover_nxt;
      recoverPulse    <= recover_nxt; // R9
      regRdData       <= rdData_nxt;
      chanPowerEnable <= {8{converterPowerOn}}; // R12
      if (regWrEn && regAddr == `CPFS_PAGE_ADDR)
        pageSel <= regWrData; // R13
    end
  end

endmodule // cpfs_status_bank
`default_nettype wire

// ==== pkg/cpfs_defines.vh ====
// What this block does
// R1: one read-only power bit per channel, channel one bit 7 to eight bit 0
// R2: bits for channels one-six from analog, seven-eight from pulse-density mics
// R3: mode field bits 7..5: 4 sleep, 6 active all off, 7 active some on
// R4: after reset the mode field reads 100b, second register reads 0x80
// R5: bit 4 of second register shows boost converter powered
// R6: bit 3 of second register shows microphone bias supply powered
// R7: bit 2 set while any analog channel is down from an input fault
// R8: bit 1 set while all analog channels are down from a bias fault
// R9: writing 1 to bit 0 rechecks faults and re-powers fault-free parts
// R10: recovery bit clears itself once recovery has been taken
// R11: host resets fault configuration register before recovery, restores after
// R12: global converter power bit 0 powers all channels down, 1 powers enabled up
// R13: paged register map, eight-bit page register, status in page zero
// R14: writes to read-only bits ignored; status tracks live state, not latched
`ifndef CPFS_DEFINES_VH
`define CPFS_DEFINES_VH
`define CPFS_PAGE_ADDR      8'h00
`define CPFS_STATUS_PAGE    8'h00
`define CPFS_CHAN_STS_ADDR  8'h76
`define CPFS_DEVICE_MODE_CODE_ADDR  8'h77
`define CPFS_PAGE_RST       8'h00
`define CPFS_CHAN_STS_RST   8'h00
`define CPFS_DEVICE_MODE_CODE_RST   8'h80
`define CPFS_MODE_SLEEP     3'h4
`define CPFS_MODE_IDLE      3'h6
`define CPFS_MODE_ACTIVE    3'h7
`define CPFS_BOOST_BIT      4
`define CPFS_MIC_BIT        3
`define CPFS_INFLT_BIT      2
`define CPFS_BIASFLT_BIT    1
`define CPFS_RECOVER_BIT    0
`endif

// ==== tb/cpfs_status_bank_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// port checker, decodes shared to keep properties short
module cpfs_status_bank_assertions(input wire logic clk,resetn,regWrEn,
  regRdEn,deviceActive,boostOn,micSupplyOn,micSupplyFault,converterPowerOn,
  recoverPulse,input wire logic [7:0] regAddr,regWrData,regRdData,
  chanPowerEnable,pageSel,input wire logic [5:0] adcChanOn,adcInputFault,
  input wire logic [1:0] pdmChanOn);
  wire logic s0=pageSel==8'h00&&regAddr==8'h76;
  wire logic s1=pageSel==8'h00&&regAddr==8'h77;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_go;regWrEn&&s1&&regWrData[0]|=>recoverPulse;endproperty
  a_go:assert property(p_go)else $error("no pulse");
  property p_one;recoverPulse|->$past(regWrEn&&s1&&regWrData[0]);endproperty
  a_one:assert property(p_one)else $error("stray pulse");
  property p_ch;regRdEn&&s0&&$stable({adcChanOn,pdmChanOn,converterPowerOn})
    |=>regRdData==$past({adcChanOn,pdmChanOn}&{8{converterPowerOn}});endproperty
  a_ch:assert property(p_ch)else $error("chan bits");
  property p_sl;regRdEn&&s1&&!deviceActive&&!$past(deviceActive)
    |=>regRdData[7:5]==3'h4;endproperty
  a_sl:assert property(p_sl)else $error("sleep code");
  property p_ft;regRdEn&&s1&&$stable(adcInputFault)
    |=>regRdData[2]==$past(|adcInputFault);endproperty
  a_ft:assert property(p_ft)else $error("fault flag");
  property p_of;regRdEn&&pageSel!=8'h00&&regAddr==8'h76|=>regRdData==8'h00;
  endproperty
  a_of:assert property(p_of)else $error("off page");
  property p_pg;regWrEn&&regAddr==8'h00|=>pageSel==$past(regWrData);endproperty
  a_pg:assert property(p_pg)else $error("page");
  property p_en;1|=>chanPowerEnable=={8{$past(converterPowerOn)}};endproperty
  a_en:assert property(p_en)else $error("enable");
endmodule // cpfs_status_bank_assertions
bind cpfs_status_bank cpfs_status_bank_assertions chk(.*);
`default_nettype wire

// ==== tb/cpfs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side, one byte per call, strobe held for one edge
module cpfs_host(input wire logic clk,output logic wrEn,rdEn,
  output logic [7:0] addr,data);
  initial {wrEn,rdEn,addr,data}=0;
  task automatic xfer(input logic w,input logic [7:0] a,d);
    @(posedge clk) #1 {wrEn,rdEn,addr,data}={w,!w,a,d};
    @(posedge clk) #1 {wrEn,rdEn}=0;
  endtask
endmodule // cpfs_host
`default_nettype wire

// ==== tb/channel_power_fault_status_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module channel_power_fault_status_tb;
  logic clk=0,resetn=0,cp,act,bst,mic,mf,wr,rd,pl;
  logic [7:0] ad,wd,rdat,en,pg,ch,e,g,q[$];
  logic [5:0] adc,flt;
  logic [1:0] pdm,pend=0;
  logic [31:0] s=32'h951d;
  int fails=0,checks_done=0;
  always #50 clk=~clk;
  cpfs_host host(.clk(clk),.wrEn(wr),.rdEn(rd),.addr(ad),.data(wd));
  cpfs_status_bank uut(.clk(clk),.resetn(resetn),.regWrEn(wr),.regRdEn(rd),
    .regAddr(ad),.regWrData(wd),.regRdData(rdat),.adcChanOn(adc),
    .pdmChanOn(pdm),.deviceActive(act),.boostOn(bst),.micSupplyOn(mic),
    .adcInputFault(flt),.micSupplyFault(mf),.converterPowerOn(cp),
    .chanPowerEnable(en),.recoverPulse(pl),.pageSel(pg));
  // note the result first, then drive
  task automatic op(input logic w,input logic [7:0] a,d,x);
    q.push_back(x);
    host.xfer(w,a,d);
  endtask
  task automatic complete_run;
    $display("fails %0d checks_done %0d",fails,checks_done);
    if (fails==0&&checks_done>0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // writes answer with the pulse, reads with data, one edge late
  always @(posedge clk) pend<={wr,rd};
  always @(negedge clk) if (pend!=0) begin
    e=q.pop_front();
    g=pend[1]?{7'h0,pl}:rdat;
    checks_done++;
    if (g!==e) begin
      fails++;
      $display("unexpected %s exp %h got %h",pend[1]?"pulse":"rdata",e,g);
    end
  end
  initial begin
    {cp,act,bst,mic,mf,adc,flt,pdm}=0;
    repeat(3) @(posedge clk);
    #1 resetn=1;
    repeat(2) @(posedge clk);
    op(0,8'h76,0,8'h00);
    op(0,8'h77,0,8'h80);
    for (int i=0;i<16;i++) begin
      s^=s<<13; s^=s>>17; s^=s<<5;
      {cp,act,bst,mic,mf,adc,flt,pdm}=s[18:0];
      @(posedge clk);
      ch={adc,pdm}&{8{cp}};
      op(1,8'h3a,0,0);
      op(1,8'h77,s[31:24],{7'h0,s[24]});
      // read after one idle edge still catches the one-cycle command bit
      op(0,8'h77,0,{act?(ch!=0?3'h7:3'h6):3'h4,bst,mic,|flt,mf,s[24]});
      op(1,8'h76,s[31:24],0);
      op(0,8'h76,0,ch);
    end
    op(1,8'h00,8'h01,0);
    op(0,8'h76,0,8'h00);
    repeat(2) @(posedge clk);
    complete_run;
  end
  // hang guard
  initial begin
    repeat(3000) @(posedge clk);
    fails++;
    complete_run;
  end
endmodule // channel_power_fault_status_tb
`default_nettype wire
